// *** inc/ehpsc_pkg.sv ***
`default_nettype none
package ehpsc_pkg;
  // ************************************
  // map and layout
  // ************************************
  localparam int NUM_PORTS = 4;
  localparam logic [7:0] PSC_BASE = 8'h64;
  localparam logic [7:0] PSC_STRIDE = 8'h04;
  localparam int WK_OC_BIT = 22;
  localparam int WK_DET_BIT = 21;
  localparam int WK_ATT_BIT = 20;
  localparam int TSEL_LSB = 16;
  localparam int IND_LSB = 14;
  localparam int OWN_BIT = 13;
  localparam int PWR_BIT = 12;
  localparam int CCS_BIT = 0;
  // ************************************
  // reset values
  // ************************************
  localparam logic OWN_RST = 1'b1;
  localparam logic PWR_RST = 1'b0;
  localparam logic WK_RST = 1'b0;
  localparam logic [3:0] TSEL_RST = 4'h0;
  localparam logic [1:0] IND_RST = 2'h0;
  // ************************************
  // test select codes
  // ************************************
  localparam logic [3:0] TSEL_J = 4'h1;
  localparam logic [3:0] TSEL_K = 4'h2;
  localparam logic [3:0] TSEL_SE0 = 4'h3;
  localparam logic [3:0] TSEL_PKT = 4'h4;
  localparam logic [3:0] TSEL_FEN = 4'h5;

  // returns {hit, index}
  function automatic logic [2:0] psc_decode(input logic [7:0] addr);
    logic [7:0] off;
    off = addr - PSC_BASE;
    psc_decode = {(addr >= PSC_BASE) && (off < 8'(NUM_PORTS * 4)) && (off[1:0] == 2'h0), off[3:2]};
  endfunction
endpackage
`default_nettype wire

// *** inc/ehpsc_port_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface ehpsc_port_if;
  logic wr_stb;
  logic [31:0] wdata;
  logic cfg_flag;
  logic cfg_rise;
  logic pwr_sw;
  logic pind;
  logic suspended;
  logic connect;
  logic overcurrent;
  logic [31:0] rdata;
  logic wake_evt;
  logic [3:0] test_sel;
  logic [1:0] indicator;
  logic owner;
  logic power;
  modport ctl (output wr_stb, wdata, cfg_flag, cfg_rise, pwr_sw, pind, suspended, connect, overcurrent,
    input rdata, wake_evt, test_sel, indicator, owner, power);
  modport port (input wr_stb, wdata, cfg_flag, cfg_rise, pwr_sw, pind, suspended, connect, overcurrent,
    output rdata, wake_evt, test_sel, indicator, owner, power);
endinterface
`default_nettype wire

// *** rtl/ehpsc_port.sv ***
`timescale 1ns/10ps
`default_nettype none
module ehpsc_port (
  // clock and control
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // register side
  ehpsc_port_if.port pif
);
  logic wk_oc_q, wk_det_q, wk_att_q, owner_q, power_q, attached_q, oc_q, wake_q;
  logic [3:0] test_sel_q;
  logic [1:0] ind_q;
  logic powered;
  logic ctl_wr;

  // without switches the port is always powered
  assign powered = !pif.pwr_sw || power_q;
  assign ctl_wr = pif.wr_stb && powered;

  // ************************************
  // software fields
  // ************************************
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wk_oc_q <= ehpsc_pkg::WK_RST;
      wk_det_q <= ehpsc_pkg::WK_RST;
      wk_att_q <= ehpsc_pkg::WK_RST;
      test_sel_q <= ehpsc_pkg::TSEL_RST;
      ind_q <= ehpsc_pkg::IND_RST;
    end else if (ce_in && ctl_wr) begin
      wk_oc_q <= pif.wdata[ehpsc_pkg::WK_OC_BIT];
      wk_det_q <= pif.wdata[ehpsc_pkg::WK_DET_BIT];
      wk_att_q <= pif.wdata[ehpsc_pkg::WK_ATT_BIT];
      test_sel_q <= pif.wdata[ehpsc_pkg::TSEL_LSB +: 4];
      if (pif.pind) begin
        ind_q <= pif.wdata[ehpsc_pkg::IND_LSB +: 2];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      power_q <= ehpsc_pkg::PWR_RST;
    end else if (ce_in && pif.wr_stb && pif.pwr_sw) begin
      power_q <= pif.wdata[ehpsc_pkg::PWR_BIT];
    end
  end

  // configure flag overrides software
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      owner_q <= ehpsc_pkg::OWN_RST;
    end else if (ce_in) begin
      if (!pif.cfg_flag) begin
        owner_q <= 1'b1;
      end else if (pif.cfg_rise) begin
        owner_q <= 1'b0;
      end else if (ctl_wr) begin
        owner_q <= pif.wdata[ehpsc_pkg::OWN_BIT];
      end
    end
  end

  // ************************************
  // status and wake
  // ************************************
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      attached_q <= 1'b0;
      oc_q <= 1'b0;
      wake_q <= 1'b0;
    end else if (ce_in) begin
      attached_q <= pif.connect && powered;
      oc_q <= pif.overcurrent && powered;
      wake_q <= pif.suspended && powered && ((pif.connect && !attached_q && wk_att_q) ||
        (!pif.connect && attached_q && wk_det_q) || (pif.overcurrent && !oc_q && wk_oc_q));
    end
  end

  // reserved bits read zero; enable bit never set here
  always_comb begin
    pif.rdata = 32'h0;
    pif.rdata[ehpsc_pkg::WK_OC_BIT] = wk_oc_q;
    pif.rdata[ehpsc_pkg::WK_DET_BIT] = wk_det_q;
    pif.rdata[ehpsc_pkg::WK_ATT_BIT] = wk_att_q;
    pif.rdata[ehpsc_pkg::TSEL_LSB +: 4] = test_sel_q;
    pif.rdata[ehpsc_pkg::IND_LSB +: 2] = ind_q;
    pif.rdata[ehpsc_pkg::OWN_BIT] = owner_q;
    pif.rdata[ehpsc_pkg::PWR_BIT] = powered;
    pif.rdata[ehpsc_pkg::CCS_BIT] = attached_q && powered;
  end

  assign pif.wake_evt = wake_q;
  assign pif.test_sel = test_sel_q;
  assign pif.indicator = ind_q;
  assign pif.owner = owner_q;
  assign pif.power = powered;

  // ************************************
  // checks
  // ************************************
  chk_reset_state: assert property (@(posedge sys_clk_in) rst_in |=>
    owner_q && test_sel_q == 4'h0 && !attached_q && !wk_oc_q)
    else $error("port state wrong after reset");
  chk_ind_locked: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && pif.wr_stb && !pif.pind |=> $stable(ind_q))
    else $error("indicator changed without support");
  chk_power_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && pif.pwr_sw && !power_q |=> $stable(test_sel_q) && $stable(wk_att_q))
    else $error("unpowered port accepted a change");
  chk_wake_awake: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && !pif.suspended |=> !wake_q)
    else $error("wake raised while running");
  chk_no_status: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    pif.pwr_sw && !power_q |-> pif.rdata[ehpsc_pkg::CCS_BIT] == 1'b0)
    else $error("unpowered port reports status");
endmodule // ehpsc_port
`default_nettype wire

// *** rtl/ehpsc_top.sv ***
// What this block does
// - aux-well registers reset only by reset
// - reset shows no device, port disabled
// - bit 22 enables wake on overcurrent
// - bit 21 enables wake on detach
// - bit 20 enables wake on attach
// - test select field, zero means normal
// - codes 1 J, 2 K, 3 SE0_NAK
// - four registers from 64h, four apart
// - ownership reset one, follows configure flag
// - indicator writes need advertised support
// - power bit gates port function
`timescale 1ns/10ps
`default_nettype none
module ehpsc_top (
  // clock and control
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // register access
  input wire logic reg_wr_en_in,
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_rdata_valid_out,
  // controller state
  input wire logic configure_flag_in,
  input wire logic power_switch_support_in,
  input wire logic indicator_support_in,
  input wire logic controller_suspended_in,
  // port lines
  input wire logic [3:0] port_connect_in,
  input wire logic [3:0] port_overcurrent_in,
  output logic [3:0] port_power_out,
  output logic [3:0] companion_ownership_out,
  output logic [7:0] indicator_control_out,
  output logic [3:0] test_j_out,
  output logic [3:0] test_k_out,
  output logic [3:0] test_se0_nak_out,
  output logic [3:0] test_packet_out,
  output logic [3:0] test_force_enable_out,
  output logic [3:0] test_active_out,
  output logic wake_request_out
);
  localparam int NP = ehpsc_pkg::NUM_PORTS;

  logic cfg_q;
  logic [2:0] wr_dec, rd_dec;
  logic [NP-1:0] wake_w, power_w, owner_w;
  logic [3:0] sel_w [NP];
  logic [1:0] ind_w [NP];
  logic [31:0] rd_w [NP];
  logic [31:0] reg_rdata_q;
  logic reg_rdata_valid_q, wake_request_q;
  logic [3:0] power_q, owner_q, j_q, k_q, se0_q, pkt_q, fen_q, act_q;
  logic [7:0] ind_q;

  ehpsc_port_if pif[NP] ();

  // ************************************
  // address decode
  // ************************************
  assign wr_dec = ehpsc_pkg::psc_decode(reg_addr_in);
  assign rd_dec = ehpsc_pkg::psc_decode(reg_addr_in);

  // edge of the configure flag, caught here once for all ports
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cfg_q <= 1'b0;
    end else if (ce_in) begin
      cfg_q <= configure_flag_in;
    end
  end

  // ************************************
  // ports
  // ************************************
  for (genvar g = 0; g < NP; g++) begin : g_port
    assign pif[g].wr_stb = reg_wr_en_in && wr_dec[2] && (wr_dec[1:0] == 2'(g));
    assign pif[g].wdata = reg_wdata_in;
    assign pif[g].cfg_flag = configure_flag_in;
    assign pif[g].cfg_rise = configure_flag_in && !cfg_q;
    assign pif[g].pwr_sw = power_switch_support_in;
    assign pif[g].pind = indicator_support_in;
    assign pif[g].suspended = controller_suspended_in;
    assign pif[g].connect = port_connect_in[g];
    assign pif[g].overcurrent = port_overcurrent_in[g];
    assign rd_w[g] = pif[g].rdata;
    assign wake_w[g] = pif[g].wake_evt;
    assign power_w[g] = pif[g].power;
    assign owner_w[g] = pif[g].owner;
    assign sel_w[g] = pif[g].test_sel;
    assign ind_w[g] = pif[g].indicator;

    ehpsc_port u_port (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .pif(pif[g])
    );
  end

  // ************************************
  // read path
  // ************************************
  // unmapped offsets answer zero, a read has no side effects
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      reg_rdata_q <= 32'h0;
      reg_rdata_valid_q <= 1'b0;
    end else if (ce_in) begin
      reg_rdata_valid_q <= reg_rd_en_in;
      if (reg_rd_en_in) begin
        reg_rdata_q <= rd_dec[2] ? rd_w[rd_dec[1:0]] : 32'h0;
      end
    end
  end

  // ************************************
  // test mode decode
  // ************************************
  // reserved nonzero codes count as test mode but drive nothing
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      j_q <= 4'h0;
      k_q <= 4'h0;
      se0_q <= 4'h0;
      pkt_q <= 4'h0;
      fen_q <= 4'h0;
      act_q <= 4'h0;
    end else if (ce_in) begin
      for (int i = 0; i < NP; i++) begin
        j_q[i] <= sel_w[i] == ehpsc_pkg::TSEL_J;
        k_q[i] <= sel_w[i] == ehpsc_pkg::TSEL_K;
        se0_q[i] <= sel_w[i] == ehpsc_pkg::TSEL_SE0;
        pkt_q[i] <= sel_w[i] == ehpsc_pkg::TSEL_PKT;
        fen_q[i] <= sel_w[i] == ehpsc_pkg::TSEL_FEN;
        act_q[i] <= sel_w[i] != ehpsc_pkg::TSEL_RST;
      end
    end
  end

  // ************************************
  // port outputs and wake
  // ************************************
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      power_q <= 4'h0;
      owner_q <= 4'hf;
      ind_q <= 8'h0;
    end else if (ce_in) begin
      power_q <= power_w;
      owner_q <= owner_w;
      for (int i = 0; i < NP; i++) begin
        ind_q[2*i +: 2] <= ind_w[i];
      end
    end
  end

  // one wake line for the controller, any port may raise it
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wake_request_q <= 1'b0;
    end else if (ce_in) begin
      wake_request_q <= |wake_w;
    end
  end

  assign reg_rdata_out = reg_rdata_q;
  assign reg_rdata_valid_out = reg_rdata_valid_q;
  assign port_power_out = power_q;
  assign companion_ownership_out = owner_q;
  assign indicator_control_out = ind_q;
  assign test_j_out = j_q;
  assign test_k_out = k_q;
  assign test_se0_nak_out = se0_q;
  assign test_packet_out = pkt_q;
  assign test_force_enable_out = fen_q;
  assign test_active_out = act_q;
  assign wake_request_out = wake_request_q;

  // ************************************
  // checks
  // ************************************
  chk_read_latency: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && reg_rd_en_in |=> reg_rdata_valid_out)
    else $error("read answer not one cycle later");
  chk_unmapped_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && reg_rd_en_in && !rd_dec[2] |=> reg_rdata_out == 32'h0)
    else $error("unmapped read not zero");
  chk_owner_release: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && configure_flag_in && !cfg_q) ##1 ce_in |=> companion_ownership_out == 4'h0)
    else $error("ownership not released on flag rise");
  chk_owner_forced: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && !configure_flag_in) ##1 ce_in |=> companion_ownership_out == 4'hf)
    else $error("ownership not forced while flag low");
  chk_test_k_decode: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in |=> test_k_out[0] == ($past(sel_w[0]) == ehpsc_pkg::TSEL_K))
    else $error("K state decode wrong");
  chk_test_normal: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && sel_w[1] == 4'h0 |=> !test_active_out[1] && !test_j_out[1])
    else $error("test drive in normal mode");
  chk_wake_quiet: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && wake_w == 4'h0 |=> !wake_request_out)
    else $error("wake without port event");
  chk_wr_readback: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && reg_wr_en_in && wr_dec == 3'b100 && power_w[0] ##1 ce_in && reg_rd_en_in && rd_dec == 3'b100
    |=> reg_rdata_out[ehpsc_pkg::WK_ATT_BIT] == $past(reg_wdata_in[ehpsc_pkg::WK_ATT_BIT], 2))
    else $error("attach wake enable not stored");
endmodule // ehpsc_top
`default_nettype wire

// *** sim/ehpsc_usb_dev.sv ***
`timescale 1ns/10ps
`default_nettype none
module ehpsc_usb_dev (
  // clock
  input wire logic sys_clk_in,
  // port side
  input wire logic [3:0] power_in,
  // scenario control
  input wire logic [3:0] attach_in,
  input wire logic [3:0] fault_in,
  // line status
  output logic [3:0] connect_out,
  output logic [3:0] overcurrent_out
);
  // ************************************
  // device lines
  // ************************************
  // an unpowered port cannot see the pull-up or draw current, so both gate on power
  always_ff @(posedge sys_clk_in) begin
    connect_out <= attach_in & power_in;
    overcurrent_out <= fault_in & power_in;
  end
endmodule // ehpsc_usb_dev
`default_nettype wire

// *** sim/tb_ehpsc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_ehpsc_top;
  // ************************************
  // signals and instances
  // ************************************
  // stands in for the 20 ms software settle wait, shortened for run time
  localparam int SETTLE_CYC = 20;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic reg_wr_en_in = 1'b0;
  logic reg_rd_en_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic configure_flag_in = 1'b0;
  logic power_switch_support_in = 1'b1;
  logic indicator_support_in = 1'b0;
  logic controller_suspended_in = 1'b0;
  logic [3:0] attach = 4'h0;
  logic [3:0] fault = 4'h0;
  logic [31:0] reg_rdata_out;
  logic reg_rdata_valid_out;
  logic [3:0] port_connect_in, port_overcurrent_in, port_power_out, companion_ownership_out;
  logic [7:0] indicator_control_out;
  logic [3:0] test_j_out, test_k_out, test_se0_nak_out, test_packet_out, test_force_enable_out, test_active_out;
  logic wake_request_out;
  int num_errors = 0;
  int n_compared = 0;
  int wake_cnt = 0;
  logic [7:0] lfsr_q = 8'h36;
  logic [2:0] sh_wk [4];
  logic [3:0] sh_tsel [4];
  logic [1:0] sh_ind [4];
  logic [3:0] sh_own, sh_pwr;
  logic [7:0] r1, r2;

  ehpsc_top ehpsc_top_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .reg_wr_en_in(reg_wr_en_in), .reg_rd_en_in(reg_rd_en_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .reg_rdata_valid_out(reg_rdata_valid_out),
    .configure_flag_in(configure_flag_in), .power_switch_support_in(power_switch_support_in),
    .indicator_support_in(indicator_support_in), .controller_suspended_in(controller_suspended_in),
    .port_connect_in(port_connect_in), .port_overcurrent_in(port_overcurrent_in),
    .port_power_out(port_power_out), .companion_ownership_out(companion_ownership_out),
    .indicator_control_out(indicator_control_out), .test_j_out(test_j_out), .test_k_out(test_k_out),
    .test_se0_nak_out(test_se0_nak_out), .test_packet_out(test_packet_out),
    .test_force_enable_out(test_force_enable_out), .test_active_out(test_active_out),
    .wake_request_out(wake_request_out));
  ehpsc_usb_dev ehpsc_usb_dev_i (.sys_clk_in(sys_clk_in), .power_in(port_power_out), .attach_in(attach),
    .fault_in(fault), .connect_out(port_connect_in), .overcurrent_out(port_overcurrent_in));

  always #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) if (wake_request_out === 1'b1) wake_cnt++;

  // ************************************
  // helpers
  // ************************************
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] exp_psc(input int p);
    return {9'h0, sh_wk[p], sh_tsel[p], sh_ind[p], sh_own[p], sh_pwr[p], 11'h0, attach[p] & sh_pwr[p]};
  endfunction
  // strobes drop here, so back-to-back accesses never drive a strobe twice in one step
  task automatic tick(input int n);
    reg_wr_en_in = 1'b0;
    reg_rd_en_in = 1'b0;
    repeat (n) begin @(posedge sys_clk_in); #1; end
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic do_reset();
    rst_in = 1'b1;
    tick(6);
    rst_in = 1'b0;
    for (int p = 0; p < 4; p++) begin sh_wk[p] = 3'h0; sh_tsel[p] = 4'h0; sh_ind[p] = 2'h0; end
    sh_own = 4'hf;
    sh_pwr = 4'h0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    reg_wr_en_in = 1'b0;
    reg_rd_en_in = 1'b1;
    reg_addr_in = a;
    @(posedge sys_clk_in);
    #1;
    check({31'h0, reg_rdata_valid_out}, 32'h1, "read valid");
    check(reg_rdata_out, exp, "read data");
  endtask
  task automatic port_wr(input int p, input logic [31:0] v);
    reg_rd_en_in = 1'b0;
    reg_wr_en_in = 1'b1;
    reg_addr_in = 8'h64 + 8'(p * 4);
    reg_wdata_in = v;
    @(posedge sys_clk_in);
    #1;
    if (power_switch_support_in) begin
      if (sh_pwr[p]) begin
        sh_wk[p] = v[22:20];
        sh_tsel[p] = v[19:16];
        if (indicator_support_in) sh_ind[p] = v[15:14];
        if (configure_flag_in) sh_own[p] = v[13];
      end
      sh_pwr[p] = v[12];
    end
  endtask
  task automatic chk_port(input int p);
    logic [3:0] t;
    t = sh_tsel[p];
    tick(3);
    check(32'({test_active_out[p], test_force_enable_out[p], test_packet_out[p], test_se0_nak_out[p],
      test_k_out[p], test_j_out[p], indicator_control_out[2*p+:2], companion_ownership_out[p], port_power_out[p]}),
      32'({t != 4'h0, t == 4'h5, t == 4'h4, t == 4'h3, t == 4'h2, t == 4'h1, sh_ind[p], sh_own[p], sh_pwr[p]}),
      "port outputs");
    rd_chk(8'h64 + 8'(p * 4), exp_psc(p));
  endtask
  // k: 0 attach, 1 detach, 2 overcurrent
  task automatic wake_case(input int p, input int k, input logic en, input logic su);
    controller_suspended_in = 1'b0;
    port_wr(p, {16'h0, sh_ind[p], sh_own[p], 13'h1000});
    if (k < 2) attach[p] = (k == 1);
    fault[p] = 1'b0;
    tick(6);
    controller_suspended_in = su;
    port_wr(p, {9'h0, 3'(en) << k, 4'h0, sh_ind[p], sh_own[p], 13'h1000});
    wake_cnt = 0;
    if (k < 2) attach[p] = (k == 0);
    else fault[p] = 1'b1;
    tick(8);
    check(32'(wake_cnt), 32'(en & su), "wake count");
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ************************************
  // tests
  // ************************************
  initial begin
    #(200000);
    num_errors++;
    $display("ERROR %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    do_reset();
    for (int p = 0; p < 4; p++) rd_chk(8'h64 + 8'(p * 4), exp_psc(p));
    rd_chk(8'h60, 32'h0);
    rd_chk(8'h66, 32'h0);
    rd_chk(8'h74, 32'h0);
    $display("test reset values done");
    for (int p = 0; p < 4; p++) begin
      attach[p] = 1'b1;
      port_wr(p, 32'h0077_2000);
      chk_port(p);
    end
    power_switch_support_in = 1'b0;
    tick(3);
    check(32'(port_power_out), 32'hf, "unswitched power");
    rd_chk(8'h64, exp_psc(0) | 32'h1001);
    power_switch_support_in = 1'b1;
    for (int p = 0; p < 4; p++) port_wr(p, 32'h0000_3000);
    tick(SETTLE_CYC);
    for (int p = 0; p < 4; p++) chk_port(p);
    $display("test power gating done");
    for (int c = 0; c < 8; c++) begin
      port_wr(1, (32'(c) << 16) | 32'h3000);
      chk_port(1);
    end
    for (int i = 0; i < 16; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      r1 = lfsr_q;
      lfsr_q = lfsr_next(lfsr_q);
      r2 = lfsr_q;
      indicator_support_in = (i < 2) ? i[0] : r2[7];
      port_wr(int'(r1[1:0]), {9'h0, r2[6:0], r1[7:6], 14'h3000});
      chk_port(int'(r1[1:0]));
    end
    port_wr(0, 32'h0010_3000);
    rd_chk(8'h64, exp_psc(0));
    $display("test fields and codes done");
    configure_flag_in = 1'b1;
    sh_own = 4'h0;
    for (int p = 0; p < 4; p++) chk_port(p);
    port_wr(2, {9'h0, sh_wk[2], sh_tsel[2], sh_ind[2], 14'h3000});
    chk_port(2);
    configure_flag_in = 1'b0;
    sh_own = 4'hf;
    for (int p = 0; p < 4; p++) chk_port(p);
    $display("test ownership done");
    for (int k = 0; k < 3; k++) begin
      wake_case(k + 1, k, 1'b0, 1'b1);
      wake_case(k + 1, k, 1'b1, 1'b0);
      wake_case(k + 1, k, 1'b1, 1'b1);
    end
    controller_suspended_in = 1'b0;
    fault = 4'h0;
    $display("test wake events done");
    do_reset();
    for (int p = 0; p < 4; p++) chk_port(p);
    $display("test second reset done");
    give_verdict();
  end
endmodule // tb_ehpsc_top
`default_nettype wire
